// file: hdl/pwm_timer_pkg.sv
package pwm_timer_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SLOW_TICK_NS = 1000000;
   localparam int SLOW_TICK_CYCLES = SLOW_TICK_NS / CLK_PERIOD_NS;

   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_CTRL = 6'h0D;
   localparam logic [5:0] IDX_CNT_H = 6'h0E;
   localparam logic [5:0] IDX_CNT_L = 6'h0F;
   localparam logic [5:0] IDX_RELOAD_H = 6'h10;
   localparam logic [5:0] IDX_RELOAD_L = 6'h11;
   localparam logic [5:0] IDX_OE = 6'h12;
   localparam logic [5:0] IDX_CHAN0 = 6'h13;
   localparam logic [5:0] IDX_DUTY0 = 6'h17;
   localparam logic [5:0] IDX_CAP_H = 6'h1F;
   localparam logic [5:0] IDX_CAP_L = 6'h20;
   localparam logic [5:0] IDX_XFER = 6'h21;
   localparam logic [5:0] IDX_BREAK = 6'h22;

   // timer_ctrl_status fields
   localparam int CS_CAPF = 6;
   localparam int CS_CAPIE = 5;
   localparam int CS_SRC_HI = 4;
   localparam int CS_SRC_LO = 3;
   localparam int CS_WRAPF = 2;
   localparam int CS_WRAPIE = 1;
   localparam int CS_MATCHIE = 0;

   // channel_ctrl_status fields
   localparam int CH_INV = 1;
   localparam int CH_MATCH = 0;

   // break_control fields
   localparam int BK_ACTIVE = 5;
   localparam int BK_GATE = 4;
   localparam int BK_PAT_HI = 3;

   // transfer register field
   localparam int XF_TRAN = 0;

   // counter source encodings
   localparam logic [1:0] SRC_SLOW = 2'h1;
   localparam logic [1:0] SRC_CPU = 2'h2;

   // reset values and counter maximum
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [11:0] RST_WORD = 12'h000;
   localparam logic RST_XFER = 1'b1;
   localparam logic [11:0] COUNT_MAX = 12'hFFF;

   typedef enum logic [1:0] {CPU_RUN, CPU_WAIT, CPU_HALT, CPU_ACTIVE_HALT} cpu_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] idx;
   } access_t;

   typedef struct packed {
      logic wrap;
      logic shared;
      logic wake;
   } irq_out_t;

endpackage

// file: hdl/autoreload_pwm_timer.sv
module autoreload_pwm_timer #(
   parameter int SLOW_TICK_DIV = pwm_timer_pkg::SLOW_TICK_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pins
   input wire logic break_pin_n,
   input wire logic capture_pin,
   output logic [3:0] pwm_out,
   output logic [3:0] pwm_drive,
   // cpu side
   input wire logic cpu_irq_mask,
   input wire pwm_timer_pkg::cpu_state_t cpu_state,
   output pwm_timer_pkg::irq_out_t irq
);
   import pwm_timer_pkg::*;

   localparam int DIV_W = $clog2(SLOW_TICK_DIV + 1);

   if (SLOW_TICK_DIV < 1)
   begin : bad_div
      $error("SLOW_TICK_DIV must be at least 1");
   end

   function automatic logic hit(input logic en, input logic [5:0] a, input logic [5:0] b);
      return en && (a == b);
   endfunction

   function automatic logic [11:0] merge12(input logic [11:0] old, input logic hi,
                                           input logic [7:0] d);
      return hi ? {d[3:0], old[7:0]} : {old[11:8], d};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [1:0] brk_sync;
   logic [1:0] cap_sync;
   logic cap_prev;
   // no capture edge until the synchroniser holds real pin levels after reset
   logic [1:0] cap_settle;
   wire cap_armed = (cap_settle == 2'h3);
   logic [DIV_W-1:0] div_count;
   logic slow_tick;

   logic capture_flag;
   logic capture_irq_enable;
   logic wrap_flag_one;
   logic wrap_irq_en_one;
   logic match_irq_enable;
   logic [1:0] counter_source_sel;
   logic [11:0] main_counter;
   logic [11:0] reload_value;
   logic [11:0] capture_value;
   logic [3:0] pwm_enable;
   logic [3:0] output_invert;
   logic [3:0] invert_shadow;
   logic [3:0] match_flag;
   logic [3:0] break_pattern;
   logic break_active;
   logic break_pin_gate;
   logic preload_transfer_enable;
   logic [11:0] duty_value [4];
   logic [11:0] active_duty [4];
   access_t dphase;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         brk_sync <= 2'h3;
         cap_sync <= 2'h0;
         cap_prev <= 1'b0;
         cap_settle <= 2'h0;
      end
      else
      begin
         brk_sync <= {brk_sync[0], break_pin_n};
         cap_sync <= {cap_sync[0], capture_pin};
         cap_prev <= cap_sync[1];
         cap_settle <= cap_armed ? cap_settle : cap_settle + 2'h1;
      end
   end

   wire break_low = !brk_sync[1];
   wire cap_edge = cap_armed && (cap_sync[1] ^ cap_prev);

   ////////////////////////////////////////////////////////////////////////////
   // slow timebase divider

   wire div_last = (div_count == DIV_W'(SLOW_TICK_DIV - 1));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_count <= '0;
         slow_tick <= 1'b0;
      end
      else
      begin
         div_count <= div_last ? '0 : div_count + DIV_W'(1);
         slow_tick <= div_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter gating and wrap

   wire slow_sel = (counter_source_sel == SRC_SLOW);
   wire cpu_sel = (counter_source_sel == SRC_CPU);
   // halted in halt; in active-halt only slow source with wrap enable runs
   wire mode_run = (cpu_state != CPU_HALT) &&
                   ((cpu_state != CPU_ACTIVE_HALT) || (slow_sel && wrap_irq_en_one));
   wire count_tick = mode_run && !break_active &&
                     ((slow_sel && slow_tick) || cpu_sel);
   wire wrap = count_tick && (main_counter == COUNT_MAX);
   wire [11:0] next_counter = break_active ? RST_WORD :
                              wrap ? reload_value :
                              count_tick ? main_counter + 12'h001 : main_counter;
   wire transfer = wrap && preload_transfer_enable;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2) && (haddr[1:0] == 2'h0);
   wire [5:0] a_idx = haddr[7:2];
   wire rd_now = addr_ok && !hwrite;
   wire wr_now = dphase.valid && dphase.write;
   wire [5:0] w_idx = dphase.idx;
   wire [7:0] wd = hwdata[7:0];

   wire rd_ctrl = hit(rd_now, a_idx, IDX_CTRL);
   wire rd_cap = hit(rd_now, a_idx, IDX_CAP_H) || hit(rd_now, a_idx, IDX_CAP_L);
   wire wr_ctrl = hit(wr_now, w_idx, IDX_CTRL);
   wire wr_reload_h = hit(wr_now, w_idx, IDX_RELOAD_H);
   wire wr_reload_l = hit(wr_now, w_idx, IDX_RELOAD_L);
   wire wr_oe = hit(wr_now, w_idx, IDX_OE);
   wire wr_xfer = hit(wr_now, w_idx, IDX_XFER);
   wire wr_break = hit(wr_now, w_idx, IDX_BREAK);

   wire [5:0] a_doff = a_idx - IDX_DUTY0;
   wire [5:0] w_doff = w_idx - IDX_DUTY0;
   wire [5:0] a_coff = a_idx - IDX_CHAN0;
   wire [5:0] w_coff = w_idx - IDX_CHAN0;
   wire a_in_duty = (a_idx >= IDX_DUTY0) && (a_idx < IDX_CAP_H);
   wire a_in_chan = (a_idx >= IDX_CHAN0) && (a_idx < IDX_DUTY0);

   ////////////////////////////////////////////////////////////////////////////
   // read mux, 12-bit values as byte pairs with zero upper nibble

   logic [7:0] rd_byte;

   always_comb
   begin
      rd_byte = RST_BYTE;
      if (a_in_duty)
         rd_byte = a_doff[0] ? duty_value[a_doff[2:1]][7:0] :
                   {4'h0, duty_value[a_doff[2:1]][11:8]};
      else if (a_in_chan)
         rd_byte = {6'h00, output_invert[a_coff[1:0]], match_flag[a_coff[1:0]]};
      else
      begin
         case (a_idx)
            IDX_CTRL: rd_byte = {1'b0, capture_flag, capture_irq_enable, counter_source_sel,
                                 wrap_flag_one, wrap_irq_en_one, match_irq_enable};
            IDX_CNT_H: rd_byte = {4'h0, main_counter[11:8]};
            IDX_CNT_L: rd_byte = main_counter[7:0];
            IDX_RELOAD_H: rd_byte = {4'h0, reload_value[11:8]};
            IDX_RELOAD_L: rd_byte = reload_value[7:0];
            IDX_OE: rd_byte = {1'b0, pwm_enable[3], 1'b0, pwm_enable[2],
                               1'b0, pwm_enable[1], 1'b0, pwm_enable[0]};
            IDX_CAP_H: rd_byte = {4'h0, capture_value[11:8]};
            IDX_CAP_L: rd_byte = capture_value[7:0];
            IDX_XFER: rd_byte = {7'h00, preload_transfer_enable};
            IDX_BREAK: rd_byte = {2'h0, break_active, break_pin_gate, break_pattern};
            default: rd_byte = RST_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait, read data latched at address phase

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dphase <= '0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         if (hready)
            dphase <= '{valid: addr_ok, write: hwrite, idx: a_idx};
         if (rd_now)
            hrdata <= {24'h000000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         capture_irq_enable <= 1'b0;
         counter_source_sel <= 2'h0;
         wrap_irq_en_one <= 1'b0;
         match_irq_enable <= 1'b0;
         reload_value <= RST_WORD;
         pwm_enable <= 4'h0;
         break_pin_gate <= 1'b0;
         break_pattern <= 4'h0;
         preload_transfer_enable <= RST_XFER;
      end
      else
      begin
         if (wr_ctrl)
         begin
            capture_irq_enable <= wd[CS_CAPIE];
            counter_source_sel <= wd[CS_SRC_HI:CS_SRC_LO];
            wrap_irq_en_one <= wd[CS_WRAPIE];
            match_irq_enable <= wd[CS_MATCHIE];
         end
         if (wr_reload_h || wr_reload_l)
            reload_value <= merge12(reload_value, wr_reload_h, wd);
         if (wr_oe)
            pwm_enable <= {wd[6], wd[4], wd[2], wd[0]};
         if (wr_break)
         begin
            break_pin_gate <= wd[BK_GATE];
            break_pattern <= wd[BK_PAT_HI:0];
         end
         // software write beats the completion clear
         if (wr_xfer)
            preload_transfer_enable <= wd[XF_TRAN];
         else if (transfer)
            preload_transfer_enable <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter, flags, capture, break

   wire next_capture_flag = (cap_edge && !capture_flag) || (capture_flag && !rd_cap);
   wire next_wrap_flag = wrap || (wrap_flag_one && !rd_ctrl);
   wire next_break = (break_pin_gate && break_low) ||
                     (wr_break ? wd[BK_ACTIVE] : break_active);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         main_counter <= RST_WORD;
         capture_flag <= 1'b0;
         capture_value <= RST_WORD;
         wrap_flag_one <= 1'b0;
         break_active <= 1'b0;
      end
      else
      begin
         main_counter <= next_counter;
         capture_flag <= next_capture_flag;
         if (cap_edge && !capture_flag)
            capture_value <= main_counter;
         wrap_flag_one <= next_wrap_flag;
         break_active <= next_break;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-channel duty, polarity, match and output

   for (genvar i = 0; i < 4; i++)
   begin : chan
      wire rd_csr = hit(rd_now, a_idx, IDX_CHAN0 + 6'(i));
      wire wr_csr = hit(wr_now, w_idx, IDX_CHAN0 + 6'(i));
      wire wr_dh = hit(wr_now, w_idx, IDX_DUTY0 + 6'(2 * i));
      wire wr_dl = hit(wr_now, w_idx, IDX_DUTY0 + 6'(2 * i + 1));
      // compare value zero never matches
      wire hit_duty = count_tick && (next_counter == active_duty[i]) &&
                      (active_duty[i] != RST_WORD);
      wire next_match = hit_duty || (match_flag[i] && !rd_csr);
      wire raw = (main_counter < active_duty[i]);
      wire next_pwm = break_active ? break_pattern[i] :
                      pwm_enable[i] && (raw ^ invert_shadow[i]);

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            duty_value[i] <= RST_WORD;
            active_duty[i] <= RST_WORD;
            output_invert[i] <= 1'b0;
            invert_shadow[i] <= 1'b0;
            match_flag[i] <= 1'b0;
            pwm_out[i] <= 1'b0;
            pwm_drive[i] <= 1'b0;
         end
         else
         begin
            if (wr_dh || wr_dl)
               duty_value[i] <= merge12(duty_value[i], wr_dh, wd);
            if (wr_csr)
               output_invert[i] <= wd[CH_INV];
            if (transfer)
            begin
               active_duty[i] <= duty_value[i];
               invert_shadow[i] <= output_invert[i];
            end
            match_flag[i] <= next_match;
            pwm_out[i] <= next_pwm;
            pwm_drive[i] <= pwm_enable[i] || break_active;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt requests and wake-up

   wire wrap_pend = wrap_flag_one && wrap_irq_en_one;
   wire shared_pend = (capture_flag && capture_irq_enable) ||
                      ((|match_flag) && match_irq_enable);
   wire next_wake = ((cpu_state == CPU_WAIT) && (wrap_pend || shared_pend)) ||
                    ((cpu_state == CPU_ACTIVE_HALT) && slow_sel && wrap_pend);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq <= '0;
      else
      begin
         irq.wrap <= wrap_pend && !cpu_irq_mask;
         irq.shared <= shared_pend && !cpu_irq_mask;
         irq.wake <= next_wake;
      end
   end

endmodule // autoreload_pwm_timer

// file: bench/autoreload_pwm_timer_properties.sv
module pwm_timer_checker #(
   parameter int SLOW_TICK_DIV = pwm_timer_pkg::SLOW_TICK_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // pins and cpu side
   input wire logic break_pin_n,
   input wire logic capture_pin,
   input wire logic [3:0] pwm_out,
   input wire logic [3:0] pwm_drive,
   input wire logic cpu_irq_mask,
   input wire pwm_timer_pkg::cpu_state_t cpu_state,
   input wire pwm_timer_pkg::irq_out_t irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   wire [5:0] idx = haddr[7:2];
   wire take_rd = hsel && htrans[1] && hready && !hwrite && hsize == 3'h2 && haddr[1:0] == 2'h0;
   wire read_hi = take_rd && (idx == IDX_CNT_H || idx == IDX_RELOAD_H || idx == IDX_CAP_H);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////
   a_ready_okay: assert property (hreadyout && !hresp)
      else $error("bus stalled or error response");
   a_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_high_nibble: assert property (read_hi |=> hrdata[7:4] == 4'h0)
      else $error("high byte upper nibble not zero");
   a_wrap_masked: assert property ($past(cpu_irq_mask) |-> !irq.wrap)
      else $error("wrap interrupt while masked");
   a_shared_masked: assert property ($past(cpu_irq_mask) |-> !irq.shared)
      else $error("shared interrupt while masked");
   a_halt_no_wake: assert property ($past(cpu_state) == CPU_HALT |-> !irq.wake)
      else $error("wake raised in halt");
   a_wait_wakes: assert property (
      $past(cpu_state) == CPU_WAIT && (irq.wrap || irq.shared) |-> irq.wake)
      else $error("pending interrupt did not wake from wait");
   a_ahalt_wrap_only: assert property (
      $past(cpu_state) == CPU_ACTIVE_HALT && !$past(cpu_irq_mask) && irq.wake |-> irq.wrap)
      else $error("active-halt wake without wrap interrupt");
   a_idle_low: assert property ((pwm_out & ~pwm_drive) == 4'h0)
      else $error("undriven channel output not low");
endmodule // pwm_timer_checker

bind autoreload_pwm_timer pwm_timer_checker #(.SLOW_TICK_DIV(SLOW_TICK_DIV)) checker_i (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
   .hreadyout, .hresp, .break_pin_n, .capture_pin, .pwm_out, .pwm_drive, .cpu_irq_mask,
   .cpu_state, .irq);

// file: bench/autoreload_pwm_timer_tb.sv
module autoreload_pwm_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   typedef struct packed {logic w; logic [5:0] idx; logic [7:0] d; logic [7:0] e;} row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic break_pin_n = 1'b1;
   logic capture_pin = 1'b0;
   logic [3:0] pwm_out;
   logic [3:0] pwm_drive;
   logic cpu_irq_mask = 1'b0;
   cpu_state_t cpu_state = CPU_RUN;
   irq_out_t irq;
   int mismatches = 0;
   int comparisons = 0;
   int n;
   logic [7:0] r;
   logic [7:0] v;
   logic [7:0] hc;
   row_t rows [17] = '{
      '{1'b0, IDX_CTRL, 8'h00, 8'h00},
      '{1'b0, IDX_CNT_H, 8'h00, 8'h00},
      '{1'b0, IDX_CNT_L, 8'h00, 8'h00},
      '{1'b0, IDX_RELOAD_L, 8'h00, 8'h00},
      '{1'b0, IDX_OE, 8'h00, 8'h00},
      '{1'b0, IDX_CHAN0, 8'h00, 8'h00},
      '{1'b0, IDX_BREAK, 8'h00, 8'h00},
      '{1'b0, IDX_CAP_H, 8'h00, 8'h00},
      '{1'b0, IDX_XFER, 8'h00, 8'h01},
      '{1'b1, IDX_RELOAD_H, 8'hFF, 8'h0F},
      '{1'b1, IDX_RELOAD_L, 8'hF0, 8'hF0},
      '{1'b1, IDX_CTRL, 8'h47, 8'h03},
      '{1'b1, IDX_CHAN0, 8'h03, 8'h02},
      '{1'b1, IDX_DUTY0, 8'hFF, 8'h0F},
      '{1'b1, 6'h3F, 8'h5A, 8'h00},
      '{1'b1, IDX_OE, 8'h55, 8'h55},
      '{1'b1, IDX_BREAK, 8'h0F, 8'h0F}
   };
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   autoreload_pwm_timer #(.SLOW_TICK_DIV(8)) autoreload_pwm_timer_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .break_pin_n, .capture_pin, .pwm_out, .pwm_drive, .cpu_irq_mask,
      .cpu_state, .irq);
   ////////////////////////////////////////////////////////////
   task automatic conclude();
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic hold();
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1)
      begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= w;
      hold();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      hold();
      r = hrdata[7:0];
   endtask
   task automatic highs();
      hc = 8'h00;
      repeat (16)
      begin
         @(posedge hclk);
         hc = hc + {7'h0, pwm_out[0]};
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            xfer(1'b1, rows[i].idx, rows[i].d);
         xfer(1'b0, rows[i].idx, 8'h00);
         chk(r, rows[i].e);
      end
      xfer(1'b1, IDX_CTRL, 8'h12);
      repeat (4200) @(posedge hclk);
      chk({7'h0, irq.wrap}, 8'h01);
      xfer(1'b1, IDX_CTRL, 8'h02);
      xfer(1'b0, IDX_CNT_H, 8'h00);
      chk(r, 8'h0F);
      xfer(1'b0, IDX_CNT_L, 8'h00);
      v = r;
      xfer(1'b0, IDX_CNT_L, 8'h00);
      chk(r, v);
      cpu_irq_mask <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({7'h0, irq.wrap}, 8'h00);
      cpu_irq_mask <= 1'b0;
      cpu_state <= CPU_WAIT;
      repeat (3) @(posedge hclk);
      chk({7'h0, irq.wake}, 8'h01);
      cpu_state <= CPU_HALT;
      repeat (3) @(posedge hclk);
      chk({7'h0, irq.wake}, 8'h00);
      cpu_state <= CPU_ACTIVE_HALT;
      repeat (3) @(posedge hclk);
      chk({7'h0, irq.wake}, 8'h00);
      xfer(1'b1, IDX_CTRL, 8'h0A);
      repeat (3) @(posedge hclk);
      chk({7'h0, irq.wake}, 8'h01);
      cpu_state <= CPU_RUN;
      xfer(1'b1, IDX_CTRL, 8'h02);
      xfer(1'b0, IDX_CTRL, 8'h00);
      chk(r, 8'h06);
      xfer(1'b0, IDX_CTRL, 8'h00);
      chk(r, 8'h02);
      // duty FF4 over reload FF0: four of sixteen high
      xfer(1'b1, IDX_DUTY0, 8'h0F);
      xfer(1'b1, IDX_DUTY0 + 6'h01, 8'hF4);
      xfer(1'b1, IDX_CHAN0, 8'h00);
      xfer(1'b1, IDX_OE, 8'h01);
      xfer(1'b1, IDX_XFER, 8'h01);
      xfer(1'b1, IDX_CTRL, 8'h13);
      repeat (40) @(posedge hclk);
      highs();
      chk(hc, 8'h04);
      chk({4'h0, pwm_drive}, 8'h01);
      chk({7'h0, irq.shared}, 8'h01);
      xfer(1'b0, IDX_CHAN0, 8'h00);
      chk(r, 8'h01);
      xfer(1'b1, IDX_CHAN0, 8'h02);
      xfer(1'b1, IDX_XFER, 8'h01);
      repeat (40) @(posedge hclk);
      highs();
      chk(hc, 8'h0C);
      capture_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      // counter stopped, capture enable on, match enable off
      xfer(1'b1, IDX_CTRL, 8'h22);
      xfer(1'b0, IDX_CNT_L, 8'h00);
      v = r;
      capture_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      chk({7'h0, irq.shared}, 8'h01);
      xfer(1'b0, IDX_CTRL, 8'h00);
      chk(r & 8'h40, 8'h40);
      xfer(1'b0, IDX_CAP_L, 8'h00);
      chk({7'h0, r !== v}, 8'h01);
      xfer(1'b0, IDX_CTRL, 8'h00);
      chk(r & 8'h40, 8'h00);
      chk({7'h0, irq.shared}, 8'h00);
      capture_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      xfer(1'b0, IDX_CAP_L, 8'h00);
      chk(r, v);
      xfer(1'b1, IDX_BREAK, 8'h05);
      break_pin_n <= 1'b0;
      repeat (8) @(posedge hclk);
      chk({4'h0, pwm_drive}, 8'h01);
      xfer(1'b1, IDX_BREAK, 8'h15);
      repeat (8) @(posedge hclk);
      xfer(1'b0, IDX_BREAK, 8'h00);
      chk(r, 8'h35);
      chk({4'h0, pwm_out}, 8'h05);
      chk({4'h0, pwm_drive}, 8'h0F);
      break_pin_n <= 1'b1;
      repeat (4) @(posedge hclk);
      xfer(1'b1, IDX_BREAK, 8'h15);
      xfer(1'b0, IDX_BREAK, 8'h00);
      chk(r, 8'h15);
      xfer(1'b1, IDX_BREAK, 8'h2A);
      repeat (3) @(posedge hclk);
      chk({4'h0, pwm_out}, 8'h0A);
      // capture pin stays high across this reset: no capture may follow it
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, IDX_BREAK, 8'h00);
      chk(r, 8'h00);
      xfer(1'b0, IDX_CTRL, 8'h00);
      chk(r, 8'h00);
      conclude();
   end
endmodule // autoreload_pwm_timer_tb
